/* wdt_pkg.sv */
// Shared constants for the watchdog time-out timer
package wdt_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
	localparam int MS_PER_FAST_SEC = 1;
	localparam int MS_PER_FAST_MIN = 60;
	localparam int MS_PER_SEC = 1000;
	localparam int MS_PER_MIN = 60000;
	localparam int PULSE_NS = 100;
	localparam int PULSE_CYCLES = (PULSE_NS / CLK_PERIOD_NS < 1) ? 1 : PULSE_NS / CLK_PERIOD_NS;

	// ==========================================================
	// Register indexes and byte addresses
	localparam logic [7:0] IDX_ACT = 8'h30;
	localparam logic [7:0] IDX_MODE = 8'hF5;
	localparam logic [7:0] IDX_COUNT = 8'hF6;
	localparam logic [7:0] IDX_CTRL = 8'hF7;
	localparam logic [7:0] IDX_ISTAT = 8'hF8;
	localparam logic [7:0] IDX_IMASK = 8'hF9;
	localparam logic [11:0] ADDR_ACT = {2'h0, IDX_ACT, 2'h0};
	localparam logic [11:0] ADDR_MODE = {2'h0, IDX_MODE, 2'h0};
	localparam logic [11:0] ADDR_COUNT = {2'h0, IDX_COUNT, 2'h0};
	localparam logic [11:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
	localparam logic [11:0] ADDR_ISTAT = {2'h0, IDX_ISTAT, 2'h0};
	localparam logic [11:0] ADDR_IMASK = {2'h0, IDX_IMASK, 2'h0};

	// ==========================================================
	// Field positions
	localparam int ACT_BIT = 0;
	localparam int MODE_FAST_BIT = 4;
	localparam int MODE_MIN_BIT = 3;
	localparam int MODE_KBC_BIT = 2;
	localparam int MODE_ROUTE_BIT = 1;
	localparam logic [7:0] MODE_MASK = 8'h1E;
	localparam int CTRL_MOUSE_BIT = 7;
	localparam int CTRL_KBD_BIT = 6;
	localparam int CTRL_TRIG_BIT = 5;
	localparam int CTRL_STAT_BIT = 4;
	localparam logic [3:0] IRQ_SEL_NONE = 4'h0;
	localparam logic [3:0] IRQ_SEL_SMI = 4'h2;
	localparam int EV_TIMEOUT = 0;
	localparam int EV_RELOAD = 1;
	localparam int EV_W = 2;

	// ==========================================================
	// Reset values
	localparam logic ACT_RST = 1'b0;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [1:0] EV_RST = 2'h0;

	typedef enum logic {
		P_IDLE = 1'b0,
		P_LOW = 1'b1
	} pulse_state_t;
endpackage : wdt_pkg

/* tick_if.sv */
// Unit tick handshake between the watchdog core and its prescaler
`timescale 1ns/100ps
interface tick_if;
	logic fast;
	logic minute;
	logic restart;
	logic tick;
	modport ctl (output fast, output minute, output restart, input tick);
	modport gen (input fast, input minute, input restart, output tick);
endinterface : tick_if

/* unit_prescaler.sv */
// Millisecond prescaler producing one tick per watchdog count unit
`timescale 1ns/100ps
module unit_prescaler import wdt_pkg::*; #(
	parameter int MS_CYCLES = MS_CYCLES_DEF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Tick handshake
	tick_if.gen tk
);
	localparam int CW = $clog2(MS_CYCLES + 1);

	typedef struct packed {
		logic [CW-1:0] cyc;
		logic [15:0] ms;
		logic tick;
	} pre_state_t;

	pre_state_t s_r;
	pre_state_t s_nxt;
	logic [15:0] ms_lim;

	assign tk.tick = s_r.tick;

	// Unit length in milliseconds from the two mode bits
	always_comb begin
		if (tk.fast) begin
			ms_lim = tk.minute ? 16'(MS_PER_FAST_MIN) : 16'(MS_PER_FAST_SEC);
		end else begin
			ms_lim = tk.minute ? 16'(MS_PER_MIN) : 16'(MS_PER_SEC);
		end
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (tk.restart) begin
			// A restart gives the counter a full first unit
			s_nxt.cyc = '0;
			s_nxt.ms = 16'h0000;
		end else if (s_r.cyc == CW'(MS_CYCLES - 1)) begin
			s_nxt.cyc = '0;
			if (s_r.ms >= ms_lim - 16'h0001) begin
				s_nxt.ms = 16'h0000;
				s_nxt.tick = 1'b1;
			end else begin
				s_nxt.ms = s_r.ms + 16'h0001;
			end
		end else begin
			s_nxt.cyc = s_r.cyc + CW'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule : unit_prescaler

/* watchdog_timeout_timer.sv */
// Watchdog time-out timer with APB register access
`timescale 1ns/100ps
module watchdog_timeout_timer import wdt_pkg::*; #(
	parameter int MS_CYCLES = MS_CYCLES_DEF
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Event pins
	input wire logic KBC_RESET_PORT_BIT,
	input wire logic MOUSE_IRQ_IN,
	input wire logic KBD_IRQ_IN,
	// Watchdog outputs
	output logic WATCHDOG_TIMEOUT_OUTPUT_N,
	output logic KEYBOARD_RESET_PIN_O,
	output logic KEYBOARD_RESET_PIN_OE,
	output logic POWER_LED_EN,
	output logic [3:0] IRQ_NUM,
	output logic IRQ_REQ,
	output logic SYSTEM_MANAGEMENT_INTERRUPT_N,
	// Block interrupt
	output logic INTR
);
	// ==========================================================
	// State
	typedef struct packed {
		// Pin synchronisers: stage 1, 2, 3 and filtered level
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] s3;
		logic [2:0] lvl;
		// Registers
		logic act;
		logic [7:0] mode;
		logic [7:0] cnt;
		logic [7:0] reload;
		logic [7:0] ctrl;
		logic [EV_W-1:0] ev;
		logic [EV_W-1:0] emask;
		// Time-out pulse
		pulse_state_t pst;
		logic [7:0] pcnt;
		logic restart;
		// Bus answer
		logic [31:0] rdata;
		logic ready;
		logic slverr;
		// Pin and interrupt outputs
		logic to_n;
		logic kbr_o;
		logic kbr_oe;
		logic led;
		logic [3:0] irq_num;
		logic irq_req;
		logic smi_n;
		logic intr;
	} wdt_state_t;

	wdt_state_t s_r;
	wdt_state_t s_nxt;
	tick_if tk ();

	logic [2:0] pins;
	logic [2:0] lvl_new;
	logic [2:0] rise;
	logic setup;
	logic wr;
	logic rd;
	logic hit;
	logic timeout;
	logic reload_ev;
	logic cnt_wr;
	logic reload_req;

	assign pins = {KBD_IRQ_IN, MOUSE_IRQ_IN, KBC_RESET_PORT_BIT};

	// ==========================================================
	// Prescaler and its tick handshake
	assign tk.fast = s_r.mode[MODE_FAST_BIT];
	assign tk.minute = s_r.mode[MODE_MIN_BIT];
	assign tk.restart = s_r.restart;

	// Runs free; a load restarts it, so the first unit after a load is a whole one
	unit_prescaler #(
		.MS_CYCLES(MS_CYCLES)
	) u_pre (
		.clk(CLK),
		.srst(SRST),
		.tk(tk.gen)
	);

	// ==========================================================
	// Pin filtering: a change counts once stages 2 and 3 agree
	// Three stages keep a metastable first stage away from the edge detector
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_sync
			assign lvl_new[g] = (s_r.s2[g] == s_r.s3[g]) ? s_r.s3[g] : s_r.lvl[g];
			assign rise[g] = lvl_new[g] & ~s_r.lvl[g];
		end
	endgenerate

	// ==========================================================
	// Bus decode
	assign setup = PSEL & ~PENABLE;
	assign wr = PSEL & PENABLE & s_r.ready & PWRITE;
	assign rd = PSEL & PENABLE & s_r.ready & ~PWRITE;
	// A load in the same cycle as a tick or a reload takes their place
	assign cnt_wr = wr & (PADDR == ADDR_COUNT);
	assign reload_req = (rise[1] & s_r.ctrl[CTRL_MOUSE_BIT])
		| (rise[2] & s_r.ctrl[CTRL_KBD_BIT]);
	// Unmapped offsets answer with an error and leave every register alone
	always_comb begin
		unique case (PADDR)
			ADDR_ACT, ADDR_MODE, ADDR_COUNT, ADDR_CTRL, ADDR_ISTAT, ADDR_IMASK: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	// ==========================================================
	// Next state
	always_comb begin
		s_nxt = s_r;
		timeout = 1'b0;
		reload_ev = 1'b0;
		s_nxt.s1 = pins;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		s_nxt.lvl = lvl_new;
		s_nxt.restart = 1'b0;
		s_nxt.ctrl[CTRL_TRIG_BIT] = 1'b0;

		// Register writes
		if (wr && hit) begin
			unique case (PADDR)
				ADDR_ACT: s_nxt.act = PWDATA[ACT_BIT];
				ADDR_MODE: s_nxt.mode = PWDATA[7:0] & MODE_MASK;
				ADDR_COUNT: begin
					s_nxt.cnt = PWDATA[7:0];
					if (PWDATA[7:0] != 8'h00) begin
						s_nxt.reload = PWDATA[7:0];
						s_nxt.restart = 1'b1;
					end
				end
				ADDR_CTRL: begin
					s_nxt.ctrl[CTRL_MOUSE_BIT] = PWDATA[CTRL_MOUSE_BIT];
					s_nxt.ctrl[CTRL_KBD_BIT] = PWDATA[CTRL_KBD_BIT];
					s_nxt.ctrl[3:0] = PWDATA[3:0];
					if (!PWDATA[CTRL_STAT_BIT]) begin
						s_nxt.ctrl[CTRL_STAT_BIT] = 1'b0;
					end
					if (PWDATA[CTRL_TRIG_BIT]) begin
						timeout = 1'b1;
					end
				end
				ADDR_IMASK: s_nxt.emask = PWDATA[EV_W-1:0];
				default: s_nxt.emask = s_r.emask;
			endcase
		end

		// Interrupt reload wins over a count tick in the same cycle
		if (reload_req) begin
			if (s_r.reload != 8'h00 && !cnt_wr) begin
				s_nxt.cnt = s_r.reload;
				s_nxt.restart = 1'b1;
				reload_ev = 1'b1;
			end
		end else if (tk.tick && s_r.act && s_r.cnt != 8'h00 && !s_r.restart) begin
			// The prescaler sees a load one cycle late, so a tick beside it is stale
			if (!cnt_wr) begin
				s_nxt.cnt = s_r.cnt - 8'h01;
				if (s_r.cnt == 8'h01) begin
					timeout = 1'b1;
				end
			end
		end

		if (rise[0] && s_r.mode[MODE_KBC_BIT]) begin
			timeout = 1'b1;
		end

		// Time-out event: status set wins over a clearing write
		if (timeout && s_r.act) begin
			s_nxt.ctrl[CTRL_STAT_BIT] = 1'b1;
			s_nxt.pst = P_LOW;
			s_nxt.pcnt = 8'(PULSE_CYCLES - 1);
		end else begin
			unique case (s_r.pst)
				P_IDLE: s_nxt.pcnt = 8'h00;
				P_LOW: begin
					if (!s_r.act) begin
						// Dropping the activation bit ends a pulse at once
						s_nxt.pst = P_IDLE;
					end else if (s_r.pcnt == 8'h00) begin
						s_nxt.pst = P_IDLE;
					end else begin
						s_nxt.pcnt = s_r.pcnt - 8'h01;
					end
				end
			endcase
		end

		// Block interrupt: sticky events, cleared by reading the status
		// A new event beats a read clear in the same cycle; one raised in the setup cycle is cleared unread
		if (rd && PADDR == ADDR_ISTAT) begin
			s_nxt.ev = '0;
		end
		if (timeout && s_r.act) begin
			s_nxt.ev[EV_TIMEOUT] = 1'b1;
		end
		if (reload_ev) begin
			s_nxt.ev[EV_RELOAD] = 1'b1;
		end
		s_nxt.intr = |(s_nxt.ev & s_nxt.emask);

		// Read data is captured in the setup cycle; one access cycle follows
		s_nxt.ready = setup;
		s_nxt.slverr = setup & ~hit;
		s_nxt.rdata = 32'h00000000;
		if (setup) begin
			unique case (PADDR)
				ADDR_ACT: s_nxt.rdata[ACT_BIT] = s_r.act;
				ADDR_MODE: s_nxt.rdata[7:0] = s_r.mode;
				ADDR_COUNT: s_nxt.rdata[7:0] = s_r.cnt;
				ADDR_CTRL: s_nxt.rdata[7:0] = s_r.ctrl;
				ADDR_ISTAT: s_nxt.rdata[EV_W-1:0] = s_r.ev;
				ADDR_IMASK: s_nxt.rdata[EV_W-1:0] = s_r.emask;
				default: s_nxt.rdata = 32'h00000000;
			endcase
		end

		// Pin outputs
		// Pins fall silent in the cycle in which the activation bit drops
		s_nxt.to_n = ~((s_nxt.pst == P_LOW) & s_nxt.act);
		s_nxt.kbr_oe = (s_nxt.pst == P_LOW) & s_nxt.mode[MODE_ROUTE_BIT] & s_nxt.act;
		s_nxt.kbr_o = 1'b0;
		s_nxt.led = s_nxt.act;
		s_nxt.irq_num = s_nxt.ctrl[3:0];
		s_nxt.irq_req = s_nxt.act & s_nxt.ctrl[CTRL_STAT_BIT]
			& (s_nxt.ctrl[3:0] != IRQ_SEL_SMI) & (s_nxt.ctrl[3:0] != IRQ_SEL_NONE);
		s_nxt.smi_n = ~(s_nxt.act & s_nxt.ctrl[CTRL_STAT_BIT]
			& (s_nxt.ctrl[3:0] == IRQ_SEL_SMI));
	end

	// ==========================================================
	// State register
	always_ff @(posedge CLK) begin
		if (SRST) begin
			// Named reset values keep the register defaults in one place
			s_r <= '0;
			s_r.act <= ACT_RST;
			s_r.mode <= MODE_RST;
			s_r.cnt <= COUNT_RST;
			s_r.reload <= COUNT_RST;
			s_r.ctrl <= CTRL_RST;
			s_r.ev <= EV_RST;
			s_r.emask <= EV_RST;
			s_r.pst <= P_IDLE;
			s_r.to_n <= 1'b1;
			s_r.smi_n <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// Outputs, each straight from the state register
	assign PRDATA = s_r.rdata;
	assign PREADY = s_r.ready;
	assign PSLVERR = s_r.slverr;
	assign WATCHDOG_TIMEOUT_OUTPUT_N = s_r.to_n;
	assign KEYBOARD_RESET_PIN_O = s_r.kbr_o;
	assign KEYBOARD_RESET_PIN_OE = s_r.kbr_oe;
	assign POWER_LED_EN = s_r.led;
	assign IRQ_NUM = s_r.irq_num;
	assign IRQ_REQ = s_r.irq_req;
	assign SYSTEM_MANAGEMENT_INTERRUPT_N = s_r.smi_n;
	assign INTR = s_r.intr;
endmodule : watchdog_timeout_timer

/* watchdog_timeout_timer_props.sv */
// Port-level checker for the watchdog time-out timer
`timescale 1ns/100ps
module watchdog_timeout_timer_props import wdt_pkg::*; (
	// Clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// Watchdog outputs
	input wire logic WATCHDOG_TIMEOUT_OUTPUT_N,
	input wire logic KEYBOARD_RESET_PIN_O,
	input wire logic KEYBOARD_RESET_PIN_OE,
	input wire logic POWER_LED_EN,
	input wire logic [3:0] IRQ_NUM,
	input wire logic IRQ_REQ,
	input wire logic SYSTEM_MANAGEMENT_INTERRUPT_N
);
	// ==========================================================
	// Properties
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);
	a_pulse_width: assert property ($fell(WATCHDOG_TIMEOUT_OUTPUT_N) |->
		(!WATCHDOG_TIMEOUT_OUTPUT_N)[*8] ##18 WATCHDOG_TIMEOUT_OUTPUT_N) else $error("bad pulse");
	a_kbr_drive: assert property (KEYBOARD_RESET_PIN_OE |->
		!KEYBOARD_RESET_PIN_O && !WATCHDOG_TIMEOUT_OUTPUT_N) else $error("bad kbd reset");
	a_idle_quiet: assert property (!POWER_LED_EN && !$past(POWER_LED_EN) |->
		!IRQ_REQ && SYSTEM_MANAGEMENT_INTERRUPT_N) else $error("irq while inactive");
	a_smi_select: assert property (!SYSTEM_MANAGEMENT_INTERRUPT_N |->
		IRQ_NUM == IRQ_SEL_SMI) else $error("smi with wrong select");
	a_irq_select: assert property (IRQ_REQ |->
		IRQ_NUM != IRQ_SEL_NONE && IRQ_NUM != IRQ_SEL_SMI) else $error("irq with wrong select");
	a_trig_fires: assert property (PSEL && PENABLE && PREADY && PWRITE && PADDR == ADDR_CTRL &&
		PWDATA[CTRL_TRIG_BIT] && POWER_LED_EN |-> ##[1:2] !WATCHDOG_TIMEOUT_OUTPUT_N)
		else $error("trigger ignored");
	a_ready_once: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY) else $error("ready");
	a_err_ready: assert property (PSLVERR |-> PREADY) else $error("slverr without ready");
	c_pulse: cover property ($fell(WATCHDOG_TIMEOUT_OUTPUT_N));
	c_smi: cover property (!SYSTEM_MANAGEMENT_INTERRUPT_N);
	c_irq: cover property (IRQ_REQ);
	c_kbr: cover property (KEYBOARD_RESET_PIN_OE);
endmodule : watchdog_timeout_timer_props

bind watchdog_timeout_timer watchdog_timeout_timer_props props (.CLK(CLK), .SRST(SRST),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .WATCHDOG_TIMEOUT_OUTPUT_N(WATCHDOG_TIMEOUT_OUTPUT_N),
	.KEYBOARD_RESET_PIN_O(KEYBOARD_RESET_PIN_O), .KEYBOARD_RESET_PIN_OE(KEYBOARD_RESET_PIN_OE),
	.POWER_LED_EN(POWER_LED_EN), .IRQ_NUM(IRQ_NUM), .IRQ_REQ(IRQ_REQ),
	.SYSTEM_MANAGEMENT_INTERRUPT_N(SYSTEM_MANAGEMENT_INTERRUPT_N));

/* watchdog_timeout_timer_test.sv */
// Self-checking bench for the watchdog time-out timer
`timescale 1ns/100ps
module watchdog_timeout_timer_test import wdt_pkg::*;;
	// ==========================================================
	// Signals
	localparam int MSC = 4;
	typedef struct packed {logic [7:0] mode; logic [7:0] cnt; int cyc;} row_t;
	// Mode, count, expected cycles to time-out
	row_t rows [5] = '{'{8'h10, 8'h01, MSC}, '{8'h10, 8'h05, MSC * 5}, '{8'h18, 8'h02, MSC * 120},
		'{8'h00, 8'h01, MSC * 1000}, '{8'h10, 8'hFF, MSC * 255}};
	logic clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0, keyboard_controller = 0, mirq = 0, kirq = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, watchdog_timeout_output_n, kbr_o, kbr_oe, led, irq_req, smi_n, intr, err;
	logic [3:0] irq_num;
	int error_cnt = 0, cmp_count = 0, n;

	always #2 clk = ~clk;

	watchdog_timeout_timer #(.MS_CYCLES(MSC)) dut (.CLK(clk), .SRST(srst), .PSEL(psel),
		.PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .KBC_RESET_PORT_BIT(keyboard_controller), .MOUSE_IRQ_IN(mirq),
		.KBD_IRQ_IN(kirq), .WATCHDOG_TIMEOUT_OUTPUT_N(watchdog_timeout_output_n), .KEYBOARD_RESET_PIN_O(kbr_o),
		.KEYBOARD_RESET_PIN_OE(kbr_oe), .POWER_LED_EN(led), .IRQ_NUM(irq_num),
		.IRQ_REQ(irq_req), .SYSTEM_MANAGEMENT_INTERRUPT_N(smi_n), .INTR(intr));

	// ==========================================================
	// Tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Releases the bus for one cycle after each transfer, so no back-to-back access
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		pen <= 1'b1;
		// No cycle count is assumed: a hang is ended by the watchdog process
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : xfer

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
		xfer(1'b0, a, 8'h00);
		chk(rd, {24'h0, e});
	endtask : rdchk

	task automatic wt(input int c);
		repeat (c) @(posedge clk);
	endtask : wt

	// Three interrupt edges 204 cycles apart, from keyboard (1) or mouse (0)
	task automatic pulses(input logic kb);
		repeat (3) begin
			wt(200);
			if (kb) kirq <= 1'b1;
			else mirq <= 1'b1;
			wt(4);
			kirq <= 1'b0;
			mirq <= 1'b0;
		end
	endtask : pulses

	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run

	// ==========================================================
	// Sequence
	initial begin
		wt(6);
		srst <= 1'b0;
		wt(1);
		rdchk(ADDR_COUNT, 8'h00);
		rdchk(ADDR_CTRL, 8'h00);
		chk({watchdog_timeout_output_n, kbr_oe, intr, smi_n}, 4'h9);
		xfer(1'b0, 12'h004, 8'h00);
		chk({err, rd[30:0]}, 32'h80000000);
		wr(ADDR_ACT, 8'h01);
		wr(ADDR_IMASK, 8'h01);
		foreach (rows[i]) begin
			wr(ADDR_MODE, rows[i].mode);
			wr(ADDR_COUNT, rows[i].cnt);
			n = 0;
			while (watchdog_timeout_output_n !== 1'b0 && n < rows[i].cyc + 40) begin
				wt(1);
				n++;
			end
			chk(n + 2 >= rows[i].cyc && n <= rows[i].cyc + 8, 1);
			chk(intr, 1);
			rdchk(ADDR_ISTAT, 8'h01);
			rdchk(ADDR_CTRL, 8'h10);
			rdchk(ADDR_COUNT, 8'h00);
			chk(intr, 0);
			wr(ADDR_CTRL, 8'h00);
			rdchk(ADDR_CTRL, 8'h00);
			wt(30);
		end
		wr(ADDR_MODE, 8'h18);
		wr(ADDR_COUNT, 8'h02);
		wt(300);
		rdchk(ADDR_COUNT, 8'h01);
		wr(ADDR_COUNT, 8'h00);
		wt(600);
		rdchk(ADDR_CTRL, 8'h00);
		wr(ADDR_CTRL, 8'h40);
		wr(ADDR_COUNT, 8'h02);
		pulses(1'b1);
		rdchk(ADDR_CTRL, 8'h40);
		pulses(1'b0);
		rdchk(ADDR_CTRL, 8'h50);
		wr(ADDR_CTRL, 8'h80);
		wr(ADDR_COUNT, 8'h02);
		pulses(1'b0);
		rdchk(ADDR_CTRL, 8'h80);
		wr(ADDR_COUNT, 8'h00);
		wr(ADDR_CTRL, 8'h00);
		rdchk(ADDR_ISTAT, 8'h03);
		wr(ADDR_IMASK, 8'h00);
		wr(ADDR_MODE, 8'h00);
		keyboard_controller <= 1'b1;
		wt(10);
		rdchk(ADDR_CTRL, 8'h00);
		keyboard_controller <= 1'b0;
		wr(ADDR_MODE, 8'h04);
		keyboard_controller <= 1'b1;
		wt(10);
		rdchk(ADDR_CTRL, 8'h10);
		chk(intr, 0);
		wr(ADDR_IMASK, 8'h01);
		wt(2);
		chk(intr, 1);
		keyboard_controller <= 1'b0;
		wt(30);
		wr(ADDR_MODE, 8'h02);
		wr(ADDR_CTRL, 8'h22);
		wt(1);
		chk({kbr_oe, kbr_o, smi_n, irq_num}, 7'h42);
		rdchk(ADDR_CTRL, 8'h12);
		wt(30);
		wr(ADDR_MODE, 8'h00);
		wr(ADDR_CTRL, 8'h25);
		wt(1);
		chk({kbr_oe, irq_req, smi_n}, 3'h3);
		wt(30);
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_ACT, 8'h00);
		wr(ADDR_CTRL, 8'h20);
		wt(3);
		chk({watchdog_timeout_output_n, led}, 2'h2);
		rdchk(ADDR_CTRL, 8'h00);
		// Reset in mid-run must bring a loaded count back to zero
		wr(ADDR_COUNT, 8'h05);
		rdchk(ADDR_COUNT, 8'h05);
		srst <= 1'b1;
		wt(2);
		srst <= 1'b0;
		wt(1);
		rdchk(ADDR_COUNT, 8'h00);
		chk({watchdog_timeout_output_n, kbr_oe, intr, smi_n}, 4'h9);
		complete_run();
	end

	// Whole run needs roughly 9000 cycles
	initial begin
		#160000;
		error_cnt++;
		complete_run();
	end
endmodule : watchdog_timeout_timer_test
